// file: mrr_pkg.sv
// shared constants, opcodes and register map of the move/return/rotate unit
`default_nettype none
package mrr_pkg;
	// datapath widths
	localparam int DATA_W = 8;
	localparam int SLOT_W = 6;
	localparam int FILE_DEPTH = 64;
	localparam int PC_W = 10;
	localparam int LEVEL_W = 4;
	localparam int STACK_DEPTH_DEF = 8;
	// register port
	localparam int BUS_W = 16;
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] REG_WORK = 3'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 3'h1;
	localparam logic [ADDR_W-1:0] REG_LEVEL = 3'h2;
	localparam logic [ADDR_W-1:0] REG_PC = 3'h3;
	localparam logic [ADDR_W-1:0] REG_PUSH = 3'h4;
	localparam logic [ADDR_W-1:0] REG_FILE_PTR = 3'h5;
	localparam logic [ADDR_W-1:0] REG_FILE_DATA = 3'h6;
	// status field positions
	localparam int ZERO_BIT = 0;
	localparam int CARRY_BIT = 1;
	localparam int GIE_BIT = 2;
	// reset values
	localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 10'h000;
	localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h0;
	localparam logic ZERO_RESET = 1'b0;
	localparam logic CARRY_RESET = 1'b0;
	localparam logic GIE_RESET = 1'b0;
	// opcodes
	typedef enum logic [2:0] {
		OP_NOP = 3'b000,
		OP_STORE_WORKING = 3'b001,
		OP_MOVE_FILE = 3'b010,
		OP_ROT_LEFT = 3'b011,
		OP_ROT_RIGHT = 3'b100,
		OP_RET_LIT = 3'b101,
		OP_RET_IRQ = 3'b110,
		OP_SUB_EXIT = 3'b111
	} op_t;
	function automatic logic is_return(op_t op);
		return (op == OP_RET_LIT) || (op == OP_RET_IRQ) || (op == OP_SUB_EXIT);
	endfunction
endpackage
`default_nettype wire

// file: mrr_ports_if.sv
// internal carriers for the file memory and the return stack
`default_nettype none
interface file_port_if;
	import mrr_pkg::*;
	logic [SLOT_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic wr_en;
	logic [SLOT_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	modport core (output rd_addr, output wr_en, output wr_addr,
		output wr_data, input rd_data);
	modport mem (input rd_addr, input wr_en, input wr_addr,
		input wr_data, output rd_data);
endinterface

interface stack_port_if;
	import mrr_pkg::*;
	logic pop;
	logic push;
	logic [PC_W-1:0] push_data;
	logic [PC_W-1:0] top;
	logic [LEVEL_W-1:0] level;
	modport core (output pop, output push, output push_data,
		input top, input level);
	modport stack (input pop, input push, input push_data,
		output top, output level);
endinterface
`default_nettype wire

// file: file_memory.sv
// data file of byte slots with registered read data
`default_nettype none
module file_memory #(
	parameter int DEPTH = mrr_pkg::FILE_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// access port
	file_port_if.mem port
);
	import mrr_pkg::*;

	logic [DATA_W-1:0] cells [DEPTH];
	logic [DATA_W-1:0] rd_data;
	logic [DATA_W-1:0] next_rd_data;

	if (DEPTH != (1 << SLOT_W)) begin : g_bad_depth
		$error("file depth must match slot address width");
	end

	// read before write: same-edge write is not seen here
	always_comb begin
		next_rd_data = cells[port.rd_addr];
	end

	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			cells[port.wr_addr] <= port.wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= WORK_RESET;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	assign port.rd_data = rd_data;
endmodule
`default_nettype wire

// file: return_stack.sv
// intentionally empty: the return stack is the mrr_stack module
`default_nettype none
`default_nettype wire

// file: mrr_stack.sv
// return address stack, entry n holds the address of level n
`default_nettype none
module mrr_stack #(
	parameter int DEPTH = mrr_pkg::STACK_DEPTH_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// stack port
	stack_port_if.stack port
);
	import mrr_pkg::*;

	logic [PC_W-1:0] entry [1:DEPTH];
	logic [LEVEL_W-1:0] level;
	logic [LEVEL_W-1:0] next_level;
	logic do_push;

	if (DEPTH < 1 || DEPTH >= (1 << LEVEL_W)) begin : g_bad_depth
		$error("stack depth out of range for level width");
	end

	// pop uses the entry at the current level, then steps down
	always_comb begin
		do_push = port.push && !port.pop && (level < LEVEL_W'(DEPTH));
		next_level = level;
		if (port.pop && level != LEVEL_RESET) begin
			next_level = level - LEVEL_W'(1);
		end else if (do_push) begin
			next_level = level + LEVEL_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= LEVEL_RESET;
		end else begin
			level <= next_level;
		end
	end

	for (genvar i = 1; i <= DEPTH; i++) begin : g_entry
		logic [PC_W-1:0] next_entry;
		always_comb begin
			next_entry = entry[i];
			if (do_push && level == LEVEL_W'(i - 1)) begin
				next_entry = port.push_data;
			end
		end
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				entry[i] <= PC_RESET;
			end else begin
				entry[i] <= next_entry;
			end
		end
	end

	always_comb begin
		port.top = (level == LEVEL_RESET) ? PC_RESET : entry[level];
	end

	assign port.level = level;
endmodule
`default_nettype wire

// file: move_return_rotate_exec.sv
// execution unit for moves, no-operation, returns and rotates
//
// The register addresses and the strobed register port are this design's own decisions.
`default_nettype none
module move_return_rotate_exec #(
	parameter int STACK_DEPTH = mrr_pkg::STACK_DEPTH_DEF
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// instruction issue
	input wire logic INSTR_VALID_IN,
	input wire mrr_pkg::op_t OPCODE_IN,
	input wire logic [mrr_pkg::SLOT_W-1:0] SLOT_IN,
	input wire logic TARGET_SEL_IN,
	input wire logic [mrr_pkg::DATA_W-1:0] LITERAL_IN,
	// register port
	input wire logic [mrr_pkg::ADDR_W-1:0] REG_ADDR_IN,
	input wire logic [mrr_pkg::BUS_W-1:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [mrr_pkg::BUS_W-1:0] REG_RDATA_OUT,
	// core state
	output logic BUSY_OUT,
	output logic DISCARD_OUT,
	output logic [mrr_pkg::PC_W-1:0] PC_OUT,
	output logic [mrr_pkg::DATA_W-1:0] WORK_OUT,
	output logic ZERO_OUT,
	output logic CARRY_OUT,
	output logic GIE_OUT,
	output logic [mrr_pkg::LEVEL_W-1:0] LEVEL_OUT
);
	import mrr_pkg::*;

	file_port_if fport();
	stack_port_if sport();

	// issue stage
	logic take;
	logic ex_valid, next_ex_valid;
	op_t ex_op, next_ex_op;
	logic [SLOT_W-1:0] ex_slot, next_ex_slot;
	logic ex_target, next_ex_target;
	logic [DATA_W-1:0] ex_lit, next_ex_lit;
	logic hold, next_hold;
	logic discard, next_discard;
	logic fwd_hit, next_fwd_hit;
	logic [DATA_W-1:0] fwd_data, next_fwd_data;
	// execute stage
	logic [DATA_W-1:0] operand;
	logic [DATA_W-1:0] result;
	logic to_dest;
	logic [PC_W-1:0] pc, next_pc;
	logic [DATA_W-1:0] work, next_work;
	logic zero, next_zero;
	logic carry, next_carry;
	logic global_irq_enable, next_gie;
	logic [SLOT_W-1:0] sw_ptr, next_sw_ptr;
	logic sw_work_wr;
	logic sw_status_wr;
	// register read
	logic [BUS_W-1:0] rdata, next_rdata;
	logic [BUS_W-1:0] status_word;

	file_memory #(.DEPTH(FILE_DEPTH)) u_file (
		.clk(CLK_IN),
		.rst_n(RST_N_IN),
		.port(fport.mem)
	);

	mrr_stack #(.DEPTH(STACK_DEPTH)) u_stack (
		.clk(CLK_IN),
		.rst_n(RST_N_IN),
		.port(sport.stack)
	);

	assign sw_work_wr = REG_WR_IN && (REG_ADDR_IN == REG_WORK);
	assign sw_status_wr = REG_WR_IN && (REG_ADDR_IN == REG_STATUS);

	// issue: slot address goes to the memory, opcode is staged
	always_comb begin
		take = INSTR_VALID_IN && !hold;
		fport.rd_addr = SLOT_IN;
		next_ex_valid = take;
		next_ex_op = OPCODE_IN;
		next_ex_slot = SLOT_IN;
		next_ex_target = TARGET_SEL_IN;
		next_ex_lit = LITERAL_IN;
		next_hold = take && is_return(OPCODE_IN);
		next_discard = INSTR_VALID_IN && hold;
		next_fwd_hit = take && fport.wr_en && (fport.wr_addr == SLOT_IN);
		next_fwd_data = fport.wr_data;
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ex_valid <= 1'b0;
			ex_op <= OP_NOP;
			ex_slot <= '0;
			ex_target <= 1'b0;
			ex_lit <= WORK_RESET;
			hold <= 1'b0;
			discard <= 1'b0;
			fwd_hit <= 1'b0;
			fwd_data <= WORK_RESET;
		end else begin
			ex_valid <= next_ex_valid;
			ex_op <= next_ex_op;
			ex_slot <= next_ex_slot;
			ex_target <= next_ex_target;
			ex_lit <= next_ex_lit;
			hold <= next_hold;
			discard <= next_discard;
			fwd_hit <= next_fwd_hit;
			fwd_data <= next_fwd_data;
		end
	end

	// execute: instruction effects override software writes
	always_comb begin
		operand = fwd_hit ? fwd_data : fport.rd_data;
		result = operand;
		to_dest = 1'b0;
		next_pc = pc;
		next_work = sw_work_wr ? REG_WDATA_IN[DATA_W-1:0] : work;
		next_zero = sw_status_wr ? REG_WDATA_IN[ZERO_BIT] : zero;
		next_carry = sw_status_wr ? REG_WDATA_IN[CARRY_BIT] : carry;
		next_gie = sw_status_wr ? REG_WDATA_IN[GIE_BIT] : global_irq_enable;
		next_sw_ptr = (REG_WR_IN && REG_ADDR_IN == REG_FILE_PTR) ?
			REG_WDATA_IN[SLOT_W-1:0] : sw_ptr;
		fport.wr_en = 1'b0;
		fport.wr_addr = ex_slot;
		fport.wr_data = work;
		sport.pop = 1'b0;
		if (ex_valid) begin
			case (ex_op)
				OP_NOP: begin
					next_pc = pc + 10'h001;
				end
				OP_STORE_WORKING: begin
					fport.wr_en = 1'b1;
					fport.wr_data = work;
					next_pc = pc + 10'h001;
				end
				OP_MOVE_FILE: begin
					result = operand;
					to_dest = 1'b1;
					next_zero = (operand == 8'h00);
					next_pc = pc + 10'h001;
				end
				OP_ROT_LEFT: begin
					result = {operand[6:0], carry};
					next_carry = operand[7];
					to_dest = 1'b1;
					next_pc = pc + 10'h001;
				end
				OP_ROT_RIGHT: begin
					result = {carry, operand[7:1]};
					next_carry = operand[0];
					to_dest = 1'b1;
					next_pc = pc + 10'h001;
				end
				OP_RET_LIT: begin
					next_work = ex_lit;
					next_gie = 1'b1;
					sport.pop = 1'b1;
					next_pc = sport.top;
				end
				OP_RET_IRQ: begin
					next_gie = 1'b1;
					sport.pop = 1'b1;
					next_pc = sport.top;
				end
				OP_SUB_EXIT: begin
					sport.pop = 1'b1;
					next_pc = sport.top;
				end
				default: begin
					next_pc = pc;
				end
			endcase
		end
		if (to_dest) begin
			if (ex_target) begin
				fport.wr_en = 1'b1;
				fport.wr_data = result;
			end else begin
				next_work = result;
			end
		end
		// software slot write only when the instruction leaves the port
		if (!fport.wr_en && REG_WR_IN && REG_ADDR_IN == REG_FILE_DATA) begin
			fport.wr_en = 1'b1;
			fport.wr_addr = sw_ptr;
			fport.wr_data = REG_WDATA_IN[DATA_W-1:0];
		end
		sport.push = REG_WR_IN && (REG_ADDR_IN == REG_PUSH);
		sport.push_data = REG_WDATA_IN[PC_W-1:0];
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pc <= PC_RESET;
			work <= WORK_RESET;
			zero <= ZERO_RESET;
			carry <= CARRY_RESET;
			global_irq_enable <= GIE_RESET;
			sw_ptr <= '0;
		end else begin
			pc <= next_pc;
			work <= next_work;
			zero <= next_zero;
			carry <= next_carry;
			global_irq_enable <= next_gie;
			sw_ptr <= next_sw_ptr;
		end
	end

	// register read, data valid only in the cycle after the strobe
	always_comb begin
		status_word = '0;
		status_word[ZERO_BIT] = zero;
		status_word[CARRY_BIT] = carry;
		status_word[GIE_BIT] = global_irq_enable;
		next_rdata = '0;
		if (REG_RD_IN) begin
			case (REG_ADDR_IN)
				REG_WORK: next_rdata = BUS_W'(work);
				REG_STATUS: next_rdata = status_word;
				REG_LEVEL: next_rdata = BUS_W'(sport.level);
				REG_PC: next_rdata = BUS_W'(pc);
				REG_FILE_PTR: next_rdata = BUS_W'(sw_ptr);
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign REG_RDATA_OUT = rdata;
	assign BUSY_OUT = hold;
	assign DISCARD_OUT = discard;
	assign PC_OUT = pc;
	assign WORK_OUT = work;
	assign ZERO_OUT = zero;
	assign CARRY_OUT = carry;
	assign GIE_OUT = global_irq_enable;
	assign LEVEL_OUT = sport.level;

	// checks
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);

	chk_store_copy: assert property (
		ex_valid && ex_op == OP_STORE_WORKING && !sw_status_wr |->
		fport.wr_en && fport.wr_addr == ex_slot && fport.wr_data == work
		##1 ZERO_OUT == $past(ZERO_OUT) && CARRY_OUT == $past(CARRY_OUT))
		else $error("store did not copy working register");
	chk_move_work: assert property (
		ex_valid && ex_op == OP_MOVE_FILE && !ex_target |=>
		WORK_OUT == $past(operand))
		else $error("move to working register wrong");
	chk_move_zero: assert property (
		ex_valid && ex_op == OP_MOVE_FILE |=>
		ZERO_OUT == ($past(operand) == 8'h00))
		else $error("zero flag wrong after move");
	chk_nop_advance: assert property (
		ex_valid && ex_op == OP_NOP && !sw_work_wr && !sw_status_wr |=>
		PC_OUT == $past(PC_OUT) + 10'h001 && $stable(WORK_OUT)
		&& $stable({ZERO_OUT, CARRY_OUT, GIE_OUT}))
		else $error("no-operation changed state");
	chk_retlit_load: assert property (
		ex_valid && ex_op == OP_RET_LIT |=>
		WORK_OUT == $past(ex_lit) && GIE_OUT && PC_OUT == $past(sport.top))
		else $error("literal return wrong");
	chk_retirq_gie: assert property (
		ex_valid && ex_op == OP_RET_IRQ && !sw_status_wr |=>
		GIE_OUT && $stable(ZERO_OUT) && $stable(CARRY_OUT))
		else $error("interrupt return wrong");
	chk_exit_keeps: assert property (
		ex_valid && ex_op == OP_SUB_EXIT && !sw_status_wr |=>
		$stable(GIE_OUT) && $stable(ZERO_OUT) && $stable(CARRY_OUT))
		else $error("subroutine exit touched flags");
	chk_pop_level: assert property (
		ex_valid && is_return(ex_op) && LEVEL_OUT != 4'h0 |=>
		LEVEL_OUT == $past(LEVEL_OUT) - 4'h1)
		else $error("stack level not decremented");
	chk_rotl_result: assert property (
		ex_valid && ex_op == OP_ROT_LEFT && !ex_target && !sw_status_wr |=>
		WORK_OUT == {$past(operand[6:0]), $past(CARRY_OUT)}
		&& CARRY_OUT == $past(operand[7]))
		else $error("rotate left wrong");
	chk_rotr_result: assert property (
		ex_valid && ex_op == OP_ROT_RIGHT && !ex_target && !sw_status_wr |=>
		WORK_OUT == {$past(CARRY_OUT), $past(operand[7:1])}
		&& CARRY_OUT == $past(operand[0]))
		else $error("rotate right wrong");
	chk_rotr_file: assert property (
		ex_valid && ex_op == OP_ROT_RIGHT && ex_target && !sw_work_wr |->
		fport.wr_en && fport.wr_addr == ex_slot
		&& fport.wr_data == {carry, operand[7:1]} ##1 $stable(WORK_OUT))
		else $error("rotate right to slot wrong");
	chk_return_slots: assert property (
		take && is_return(OPCODE_IN) |=> BUSY_OUT ##1 !BUSY_OUT)
		else $error("return did not hold one slot");
	chk_discard_slot: assert property (
		INSTR_VALID_IN && BUSY_OUT |=> !ex_valid && DISCARD_OUT)
		else $error("instruction after return not discarded");

	cov_ret_lit: cover property (ex_valid && ex_op == OP_RET_LIT);
	cov_discard: cover property (INSTR_VALID_IN && BUSY_OUT);
	cov_forward: cover property (ex_valid && fwd_hit);
	cov_rotr_file: cover property (ex_valid && ex_op == OP_ROT_RIGHT && ex_target);
endmodule
`default_nettype wire

// file: test_move_return_rotate_exec.sv
// self-checking bench for the move/return/rotate execution unit
`default_nettype none
module test_move_return_rotate_exec;
	timeunit 1ns;
	timeprecision 1ps;
	import mrr_pkg::*;
	typedef struct {
		string name;
		logic [BUS_W-1:0] exp;
	} note_t;
	logic clk, rst_n, valid, tsel, reg_wr, reg_rd, rd_d;
	op_t opcode;
	logic [SLOT_W-1:0] slot, sl;
	logic [DATA_W-1:0] lit, e_w, v;
	logic [ADDR_W-1:0] reg_addr;
	logic [BUS_W-1:0] reg_wdata, rdata;
	logic busy, discard, zero, carry, global_irq_enable, e_z, e_c, e_g;
	logic [PC_W-1:0] pc, e_pc;
	logic [DATA_W-1:0] work;
	logic [LEVEL_W-1:0] level, e_lvl;
	logic [PC_W-1:0] stk [16];
	logic [DATA_W-1:0] mem [FILE_DEPTH];
	note_t notes[$];
	int bad_count = 0, n_compared = 0, cycles = 0, n_disc = 0, d0;
	int n_busy = 0, b0;

	move_return_rotate_exec #(.STACK_DEPTH(8)) move_return_rotate_exec_inst (
		.CLK_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(valid),
		.OPCODE_IN(opcode), .SLOT_IN(slot), .TARGET_SEL_IN(tsel),
		.LITERAL_IN(lit), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata),
		.REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdata),
		.BUSY_OUT(busy), .DISCARD_OUT(discard), .PC_OUT(pc),
		.WORK_OUT(work), .ZERO_OUT(zero), .CARRY_OUT(carry),
		.GIE_OUT(global_irq_enable), .LEVEL_OUT(level));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(string name, logic [BUS_W-1:0] seen,
			logic [BUS_W-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		note_t n;
		if (rd_d) begin
			n = notes.pop_front();
			check(n.name, rdata, n.exp);
		end
		rd_d <= reg_rd;
		if (discard === 1'b1) n_disc++;
		if (busy === 1'b1) n_busy++;
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			test_done();
		end
	end

	task automatic wr(logic [ADDR_W-1:0] a, logic [BUS_W-1:0] d);
		valid <= 1'b0;
		reg_rd <= 1'b0;
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
	endtask

	task automatic rd(logic [ADDR_W-1:0] a, string name, logic [BUS_W-1:0] e);
		notes.push_back('{name, e});
		valid <= 1'b0;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
	endtask

	task automatic idle(int n);
		valid <= 1'b0;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	task automatic instr(op_t op, logic [SLOT_W-1:0] s, logic t,
			logic [DATA_W-1:0] l);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		valid <= 1'b1;
		opcode <= op;
		slot <= s;
		tsel <= t;
		lit <= l;
		@(posedge clk);
	endtask

	// issue one instruction and update the expected state
	task automatic ex(op_t op, logic [SLOT_W-1:0] s, logic t,
			logic [DATA_W-1:0] l);
		logic [DATA_W-1:0] r;
		r = mem[s];
		instr(op, s, t, l);
		e_pc = e_pc + 10'h001;
		case (op)
			OP_NOP: ;
			OP_STORE_WORKING: mem[s] = e_w;
			OP_MOVE_FILE: e_z = (r == 8'h00);
			OP_ROT_LEFT: {e_c, r} = {r, e_c};
			OP_ROT_RIGHT: {r, e_c} = {e_c, r};
			default: begin
				e_pc = (e_lvl == 4'h0) ? 10'h000 : stk[e_lvl];
				if (e_lvl != 4'h0) e_lvl = e_lvl - 4'h1;
				if (op == OP_RET_LIT) e_w = l;
				if (op != OP_SUB_EXIT) e_g = 1'b1;
			end
		endcase
		if (op inside {OP_MOVE_FILE, OP_ROT_LEFT, OP_ROT_RIGHT}) begin
			if (t) mem[s] = r;
			else e_w = r;
		end
	endtask

	task automatic chk;
		idle(3);
		check("pin work", 16'(work), 16'(e_w));
		check("pin zero", 16'(zero), 16'(e_z));
		check("pin carry", 16'(carry), 16'(e_c));
		check("pin gie", 16'(global_irq_enable), 16'(e_g));
		check("pin pc", 16'(pc), 16'(e_pc));
		check("pin level", 16'(level), 16'(e_lvl));
		check("pin busy", 16'(busy), 16'h0000);
		rd(REG_WORK, "work", {8'h00, e_w});
		rd(REG_STATUS, "status", {13'h0000, e_g, e_c, e_z});
		rd(REG_PC, "pc", {6'h00, e_pc});
		rd(REG_LEVEL, "level", {12'h000, e_lvl});
		idle(2);
	endtask

	task automatic load(logic [SLOT_W-1:0] s, logic [DATA_W-1:0] d);
		wr(REG_FILE_PTR, {10'h000, s});
		wr(REG_FILE_DATA, {8'h00, d});
		mem[s] = d;
	endtask

	task automatic setw(logic [DATA_W-1:0] d);
		wr(REG_WORK, {8'h00, d});
		e_w = d;
	endtask

	task automatic setst(logic z, logic c, logic g);
		wr(REG_STATUS, {13'h0000, g, c, z});
		{e_g, e_c, e_z} = {g, c, z};
	endtask

	task automatic push(logic [PC_W-1:0] a);
		wr(REG_PUSH, {6'h00, a});
		e_lvl = e_lvl + 4'h1;
		stk[e_lvl] = a;
	endtask

	initial begin
		{rst_n, valid, tsel, reg_wr, reg_rd} = 5'h00;
		opcode = OP_NOP;
		slot = 6'h00;
		lit = 8'h00;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		{e_w, e_z, e_c, e_g, e_pc, e_lvl} = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		void'($urandom(32'h2c1b));
		@(posedge clk);
		chk();
		rd(3'h7, "unmapped", 16'h0000);
		idle(2);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			sl = (i == 0) ? 6'h3f : 6'($urandom % FILE_DEPTH);
			v = (i % 3 == 1) ? 8'h00 : 8'($urandom);
			setw(v);
			setst(1'b1, 1'b1, 1'b0);
			ex(OP_STORE_WORKING, sl, 1'b0, 8'h00);
			chk();
			setw(~v);
			ex(OP_MOVE_FILE, sl, i[0], 8'h00);
			ex(OP_MOVE_FILE, sl, 1'b0, 8'h00);
			chk();
		end
		setw(8'h00);
		ex(OP_STORE_WORKING, 6'h09, 1'b0, 8'h00);
		ex(OP_MOVE_FILE, 6'h09, 1'b1, 8'h00);
		chk();
		$display("test store and move done");
		setst(1'b1, 1'b0, 1'b1);
		ex(OP_NOP, 6'h00, 1'b0, 8'h00);
		ex(OP_NOP, 6'h00, 1'b0, 8'h00);
		ex(OP_NOP, 6'h00, 1'b0, 8'h00);
		chk();
		$display("test no-operation done");
		for (int i = 0; i < 16; i++) begin
			sl = 6'($urandom % FILE_DEPTH);
			load(sl, (i < 2) ? 8'ha5 : 8'($urandom));
			setst(i[3], i[2], 1'b0);
			ex(i[0] ? OP_ROT_RIGHT : OP_ROT_LEFT, sl, i[1], 8'h00);
			chk();
			ex(OP_MOVE_FILE, sl, 1'b0, 8'h00);
			chk();
		end
		$display("test rotates done");
		d0 = n_disc;
		b0 = n_busy;
		setst(1'b1, 1'b1, 1'b0);
		push(10'h123);
		push(10'h2ab);
		ex(OP_RET_LIT, 6'h00, 1'b0, 8'h55);
		chk();
		setst(1'b1, 1'b0, 1'b0);
		ex(OP_RET_IRQ, 6'h00, 1'b0, 8'h00);
		chk();
		push(10'h3ff);
		setst(1'b0, 1'b1, 1'b0);
		ex(OP_SUB_EXIT, 6'h00, 1'b0, 8'h00);
		chk();
		ex(OP_SUB_EXIT, 6'h00, 1'b0, 8'h00);
		chk();
		check("no discard", 16'(n_disc - d0), 16'h0000);
		check("busy slots", 16'(n_busy - b0), 16'h0004);
		$display("test returns done");
		load(6'h02, 8'h3c);
		push(10'h155);
		setw(8'h77);
		ex(OP_SUB_EXIT, 6'h00, 1'b0, 8'h00);
		instr(OP_STORE_WORKING, 6'h02, 1'b0, 8'h00);
		instr(OP_NOP, 6'h00, 1'b0, 8'h00);
		e_pc = e_pc + 10'h001;
		chk();
		check("discard", 16'(n_disc - d0), 16'h0001);
		check("busy slots", 16'(n_busy - b0), 16'h0005);
		ex(OP_MOVE_FILE, 6'h02, 1'b0, 8'h00);
		chk();
		$display("test discard done");
		test_done();
	end
endmodule
`default_nettype wire
